// ### src/dicc_top.sv
// Instruction class control package and top-level sequencer
`timescale 1ns/1ps
package dicc_pkg;
	// ----------------------------------------
	// Instruction word fields
	// ----------------------------------------
	localparam int OPC_HI = 23;
	localparam int OPC_LO = 19;
	localparam int DST_BIT = 18;
	localparam int LONG_BIT = 12;
	localparam int IND_BIT = 11;
	localparam int CNT_HI = 10;
	localparam int IMM_HI = 7;
	localparam int BITSEL_HI = 4;
	// ----------------------------------------
	// Opcodes
	// ----------------------------------------
	localparam logic [4:0] OP_NOP = 5'h00;
	localparam logic [4:0] OP_AND = 5'h01;
	localparam logic [4:0] OP_AND_IMM_TO_CONTROL = 5'h02;
	localparam logic [4:0] OP_EXCLUSIVE_OR = 5'h03;
	localparam logic [4:0] OP_OR = 5'h04;
	localparam logic [4:0] OP_OR_IMM_TO_CONTROL = 5'h05;
	localparam logic [4:0] OP_NOT = 5'h06;
	localparam logic [4:0] OP_LOGIC_SHIFT_LEFT = 5'h07;
	localparam logic [4:0] OP_LOGIC_SHIFT_RIGHT = 5'h08;
	localparam logic [4:0] OP_ROTATE_LEFT = 5'h09;
	localparam logic [4:0] OP_ROTATE_RIGHT = 5'h0a;
	localparam logic [4:0] OP_BIT_CLEAR = 5'h0b;
	localparam logic [4:0] OP_BIT_SET = 5'h0c;
	localparam logic [4:0] OP_BIT_CHANGE = 5'h0d;
	localparam logic [4:0] OP_BIT_TEST = 5'h0e;
	localparam logic [4:0] OP_JUMP_IF_CLEAR = 5'h0f;
	localparam logic [4:0] OP_JUMP_IF_SET = 5'h10;
	localparam logic [4:0] OP_CALL_IF_CLEAR = 5'h11;
	localparam logic [4:0] OP_CALL_IF_SET = 5'h12;
	localparam logic [4:0] OP_HW_LOOP_START = 5'h13;
	localparam logic [4:0] OP_HW_LOOP_ABORT = 5'h14;
	localparam logic [4:0] OP_MOVE = 5'h15;
	localparam logic [4:0] OP_REPEAT_NEXT = 5'h16;
	localparam logic [4:0] OP_STOP = 5'h17;
	localparam logic [4:0] OP_WAIT = 5'h18;
	localparam logic [4:0] OP_PERIPH_RESET = 5'h19;
	localparam logic [4:0] OP_SOFT_INTERRUPT = 5'h1a;
	localparam logic [4:0] OP_JUMP = 5'h1b;
	localparam logic [4:0] OP_ILLEGAL = 5'h1f;
	// ----------------------------------------
	// Condition code bits and stack
	// ----------------------------------------
	localparam int CCR_C = 0;
	localparam int CCR_V = 1;
	localparam int CCR_Z = 2;
	localparam int CCR_N = 3;
	localparam int CCR_L = 6;
	localparam int STK_AW = 4;
	localparam int STK_DW = 16;
	localparam logic [STK_AW-1:0] STK_ONE = 4'h1;
	localparam logic [15:0] ONE16 = 16'h0001;
	localparam logic [23:0] BIT0_24 = 24'h000001;

	typedef enum logic [3:0] {
		S_IDLE, S_EXT, S_REPEAT, S_DO1, S_DO2, S_END0, S_END1, S_END2, S_END3, S_STOP, S_WAIT
	} dicc_st_t;

	typedef struct packed {
		dicc_st_t st;
		logic [23:0] held;
		logic [23:0] ext;
		logic [7:0] ccr;
		logic [7:0] mr;
		logic [15:0] loop_address_reg;
		logic [15:0] loop_counter_reg;
		logic [15:0] loop_start;
		logic [15:0] pend_addr;
		logic [15:0] pend_cnt;
		logic [15:0] pend_start;
		logic [3:0] depth;
		logic [STK_AW-1:0] sp;
		logic [10:0] repeat_left;
		logic repeat_arm;
		logic ready;
		logic [23:0] res;
		logic res_we;
		logic res_b;
		logic par_move;
		logic mem_we;
		logic [23:0] mem_wdata;
		logic jump;
		logic jsub;
		logic [15:0] target;
		logic redirect;
		logic [15:0] redir_addr;
		logic irq_take;
		logic ill_irq;
		logic soft_irq;
		logic prst;
		logic osc_off;
		logic low_power;
		logic loop_active;
	} dicc_state_t;

	localparam dicc_state_t RST_STATE = '0;
endpackage

module dicc_top import dicc_pkg::*; (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_instr_valid,
	input wire logic [23:0] i_instr_word,
	input wire logic [15:0] i_instr_pc,
	input wire logic [23:0] i_src_word,
	input wire logic [23:0] i_acc_a_mid,
	input wire logic [23:0] i_acc_b_mid,
	input wire logic [23:0] i_mem_word,
	input wire logic i_limit_hit,
	input wire logic i_irq_req,
	output logic o_ready,
	output logic [23:0] o_result,
	output logic o_result_we,
	output logic o_result_to_b,
	output logic [7:0] o_ccr,
	output logic [7:0] o_mode_reg,
	output logic o_par_move_en,
	output logic o_mem_we,
	output logic [23:0] o_mem_wdata,
	output logic o_jump,
	output logic o_jump_sub,
	output logic [15:0] o_target,
	output logic o_loop_redirect,
	output logic [15:0] o_redirect_addr,
	output logic o_loop_active,
	output logic o_irq_take,
	output logic o_illegal_irq,
	output logic o_soft_irq,
	output logic o_periph_rst,
	output logic o_osc_off,
	output logic o_low_power
);
	dicc_state_t r;
	dicc_state_t n;
	logic stk_we;
	logic [STK_AW-1:0] stk_wa;
	logic [STK_AW-1:0] stk_ra;
	logic [STK_DW-1:0] stk_wd;
	logic [STK_DW-1:0] stk_rd;

	dicc_stack_mem dicc_stack_mem_inst (
		.i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst),
		.i_wr_en(stk_we),
		.i_wr_addr(stk_wa),
		.i_wr_data(stk_wd),
		.i_rd_addr(stk_ra),
		.o_rd_data(stk_rd)
	);

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		logic [23:0] w;
		logic [23:0] ext;
		logic [23:0] acc;
		logic [23:0] bmask;
		logic [4:0] opc;
		logic exec;
		logic bitv;
		logic logic_op;
		n = r;
		w = (r.st == S_IDLE) ? i_instr_word : r.held;
		ext = (r.st == S_EXT) ? i_instr_word : r.ext;
		opc = w[OPC_HI:OPC_LO];
		acc = w[DST_BIT] ? i_acc_b_mid : i_acc_a_mid;
		bmask = BIT0_24 << w[BITSEL_HI:0];
		bitv = |(i_mem_word & bmask);
		logic_op = 1'b0;
		exec = 1'b0;
		stk_we = 1'b0;
		stk_wa = r.sp;
		stk_wd = r.loop_address_reg;
		stk_ra = r.sp - STK_ONE;
		n.res_we = 1'b0;
		n.mem_we = 1'b0;
		n.jump = 1'b0;
		n.jsub = 1'b0;
		n.redirect = 1'b0;
		n.irq_take = 1'b0;
		n.ill_irq = 1'b0;
		n.soft_irq = 1'b0;
		n.prst = 1'b0;
		n.par_move = 1'b0;
		unique case (r.st)
			S_IDLE: begin
				if (r.ready && i_instr_valid) begin
					if (i_instr_word[LONG_BIT]) begin
						n.held = i_instr_word;
						n.st = S_EXT;
					end else begin
						n.ext = '0;
						exec = 1'b1;
					end
				end else if (!r.ready && i_irq_req && !r.repeat_arm) begin
					n.irq_take = 1'b1;
				end
			end
			S_EXT: begin
				if (r.ready && i_instr_valid) begin
					n.ext = i_instr_word;
					n.st = S_IDLE;
					exec = 1'b1;
				end
			end
			S_REPEAT: begin
				exec = 1'b1;
				n.repeat_left = r.repeat_left - 11'h001;
				if (r.repeat_left == 11'h001) begin
					n.st = S_IDLE;
				end
			end
			S_DO1: begin
				stk_we = 1'b1;
				stk_wd = r.loop_counter_reg;
				n.sp = r.sp + STK_ONE;
				n.st = S_DO2;
			end
			S_DO2: begin
				stk_we = 1'b1;
				stk_wd = r.pend_start;
				n.sp = r.sp + STK_ONE;
				n.loop_address_reg = r.pend_addr;
				n.loop_counter_reg = r.pend_cnt;
				n.loop_start = r.pend_start;
				n.depth = r.depth + 4'h1;
				n.st = S_IDLE;
			end
			S_END0: begin
				stk_ra = r.sp - 4'h2;
				n.st = S_END1;
			end
			S_END1: begin
				n.loop_counter_reg = stk_rd;
				stk_ra = r.sp - 4'h3;
				n.st = S_END2;
			end
			S_END2: begin
				n.loop_address_reg = stk_rd;
				stk_ra = r.sp - 4'h4;
				n.st = S_END3;
			end
			S_END3: begin
				if (r.depth > 4'h1) begin
					n.loop_start = stk_rd;
				end
				n.sp = r.sp - 4'h3;
				n.depth = r.depth - 4'h1;
				n.st = S_IDLE;
			end
			S_STOP, S_WAIT: begin
				if (i_irq_req) begin
					n.irq_take = 1'b1;
					n.st = S_IDLE;
				end
			end
		endcase

		if (exec) begin
			unique case (opc)
				OP_AND: begin
					n.res = acc & i_src_word;
					logic_op = 1'b1;
				end
				OP_EXCLUSIVE_OR: begin
					n.res = acc ^ i_src_word;
					logic_op = 1'b1;
				end
				OP_OR: begin
					n.res = acc | i_src_word;
					logic_op = 1'b1;
				end
				OP_NOT: begin
					n.res = ~acc;
					logic_op = 1'b1;
				end
				OP_LOGIC_SHIFT_LEFT: begin
					n.res = {acc[22:0], 1'b0};
					n.ccr[CCR_C] = acc[23];
					logic_op = 1'b1;
				end
				OP_LOGIC_SHIFT_RIGHT: begin
					n.res = {1'b0, acc[23:1]};
					n.ccr[CCR_C] = acc[0];
					logic_op = 1'b1;
				end
				OP_ROTATE_LEFT: begin
					n.res = {acc[22:0], r.ccr[CCR_C]};
					n.ccr[CCR_C] = acc[23];
					logic_op = 1'b1;
				end
				OP_ROTATE_RIGHT: begin
					n.res = {r.ccr[CCR_C], acc[23:1]};
					n.ccr[CCR_C] = acc[0];
					logic_op = 1'b1;
				end
				OP_AND_IMM_TO_CONTROL: begin
					// No parallel move: the immediate owns the data path
					if (w[DST_BIT]) begin
						n.mr = r.mr & w[IMM_HI:0];
					end else begin
						n.ccr = r.ccr & w[IMM_HI:0];
					end
				end
				OP_OR_IMM_TO_CONTROL: begin
					if (w[DST_BIT]) begin
						n.mr = r.mr | w[IMM_HI:0];
					end else begin
						n.ccr = r.ccr | w[IMM_HI:0];
					end
				end
				OP_BIT_CLEAR, OP_BIT_SET, OP_BIT_CHANGE, OP_BIT_TEST: begin
					n.ccr[CCR_C] = bitv;
					n.mem_we = (opc != OP_BIT_TEST);
					n.mem_wdata = (opc == OP_BIT_CLEAR) ? (i_mem_word & ~bmask) :
						(opc == OP_BIT_SET) ? (i_mem_word | bmask) : (i_mem_word ^ bmask);
				end
				OP_JUMP_IF_CLEAR, OP_JUMP_IF_SET, OP_CALL_IF_CLEAR, OP_CALL_IF_SET: begin
					n.target = ext[15:0];
					n.jump = (opc == OP_JUMP_IF_SET) ? bitv : (opc == OP_JUMP_IF_CLEAR) ? !bitv : 1'b0;
					n.jsub = (opc == OP_CALL_IF_SET) ? bitv : (opc == OP_CALL_IF_CLEAR) ? !bitv : 1'b0;
				end
				OP_JUMP: begin
					n.target = ext[15:0];
					n.jump = 1'b1;
				end
				OP_HW_LOOP_START: begin
					stk_we = 1'b1;
					n.sp = r.sp + STK_ONE;
					n.pend_addr = ext[15:0];
					n.pend_cnt = w[IND_BIT] ? i_mem_word[15:0] : {5'h00, w[CNT_HI:0]};
					n.pend_start = i_instr_pc + ONE16;
					n.st = S_DO1;
				end
				OP_HW_LOOP_ABORT: begin
					if (r.depth != 4'h0) begin
						n.st = S_END0;
					end
				end
				OP_MOVE: begin
					n.par_move = 1'b1;
					if (i_limit_hit) begin
						n.ccr[CCR_L] = 1'b1;
					end
				end
				OP_REPEAT_NEXT: begin
					n.repeat_arm = 1'b1;
					n.repeat_left = (w[CNT_HI:0] == 11'h000) ? 11'h001 : w[CNT_HI:0];
				end
				OP_STOP: n.st = S_STOP;
				OP_WAIT: n.st = S_WAIT;
				OP_PERIPH_RESET: n.prst = 1'b1;
				OP_SOFT_INTERRUPT: n.soft_irq = 1'b1;
				OP_NOP: n.par_move = 1'b0;
				default: n.ill_irq = 1'b1;
			endcase

			if (logic_op) begin
				n.res_we = 1'b1;
				n.res_b = w[DST_BIT];
				n.par_move = 1'b1;
				n.ccr[CCR_N] = n.res[23];
				n.ccr[CCR_Z] = (n.res == 24'h000000);
				n.ccr[CCR_V] = 1'b0;
			end

			// The repeated word is kept so it is never fetched again
			if (r.repeat_arm && r.st != S_REPEAT && opc != OP_REPEAT_NEXT) begin
				n.repeat_arm = 1'b0;
				n.held = w;
				n.ext = ext;
				n.repeat_left = r.repeat_left - 11'h001;
				if (r.repeat_left != 11'h001 && n.st == S_IDLE) begin
					n.st = S_REPEAT;
				end
			end

			// Loop end test runs beside the ALU op in the same cycle
			if (r.st != S_REPEAT && r.depth != 4'h0 && i_instr_pc == r.loop_address_reg && n.st == S_IDLE) begin
				if (r.loop_counter_reg > ONE16) begin
					n.loop_counter_reg = r.loop_counter_reg - ONE16;
					n.redirect = 1'b1;
					n.redir_addr = r.loop_start;
				end else begin
					n.st = S_END0;
				end
			end
		end

		n.ready = (n.st == S_EXT) || (n.st == S_IDLE && !(i_irq_req && !n.repeat_arm));
		n.osc_off = (n.st == S_STOP);
		n.low_power = (n.st == S_STOP) || (n.st == S_WAIT);
		n.loop_active = (n.depth != 4'h0);
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			r <= RST_STATE;
		end else begin
			r <= n;
		end
	end

	assign o_ready = r.ready;
	assign o_result = r.res;
	assign o_result_we = r.res_we;
	assign o_result_to_b = r.res_b;
	assign o_ccr = r.ccr;
	assign o_mode_reg = r.mr;
	assign o_par_move_en = r.par_move;
	assign o_mem_we = r.mem_we;
	assign o_mem_wdata = r.mem_wdata;
	assign o_jump = r.jump;
	assign o_jump_sub = r.jsub;
	assign o_target = r.target;
	assign o_loop_redirect = r.redirect;
	assign o_redirect_addr = r.redir_addr;
	assign o_loop_active = r.loop_active;
	assign o_irq_take = r.irq_take;
	assign o_illegal_irq = r.ill_irq;
	assign o_soft_irq = r.soft_irq;
	assign o_periph_rst = r.prst;
	assign o_osc_off = r.osc_off;
	assign o_low_power = r.low_power;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	logic acc_short;
	logic [4:0] in_opc;
	assign acc_short = r.st == S_IDLE && r.ready && i_instr_valid && !i_instr_word[LONG_BIT] && !r.repeat_arm;
	assign in_opc = i_instr_word[OPC_HI:OPC_LO];

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);

	property p_logic_flags;
		o_result_we |-> o_ccr[CCR_Z] == (o_result == 24'h000000) && o_ccr[CCR_N] == o_result[23];
	endproperty
	a_logic_flags: assert property (p_logic_flags) else $error("flags disagree with result");

	property p_logic_one_cycle;
		acc_short && in_opc == OP_AND |=> o_result_we && o_par_move_en && o_result == $past(
			(i_instr_word[DST_BIT] ? i_acc_b_mid : i_acc_a_mid) & i_src_word);
	endproperty
	a_logic_one_cycle: assert property (p_logic_one_cycle) else $error("logical result late or wrong");

	property p_ctrl_imm_no_move;
		acc_short && (in_opc == OP_AND_IMM_TO_CONTROL || in_opc == OP_OR_IMM_TO_CONTROL)
			|=> !o_par_move_en && !o_result_we;
	endproperty
	a_ctrl_imm_no_move: assert property (p_ctrl_imm_no_move) else $error("control immediate moved data");

	property p_bit_carry;
		acc_short && in_opc >= OP_BIT_CLEAR && in_opc <= OP_BIT_TEST
			|=> o_ccr[CCR_C] == $past(|(i_mem_word & (BIT0_24 << i_instr_word[BITSEL_HI:0]))) && !o_par_move_en;
	endproperty
	a_bit_carry: assert property (p_bit_carry) else $error("bit test carry wrong");

	property p_move_keeps_ccr;
		acc_short && in_opc == OP_MOVE && !i_limit_hit |=> $stable(o_ccr);
	endproperty
	a_move_keeps_ccr: assert property (p_move_keeps_ccr) else $error("move changed codes");

	property p_loop_push;
		r.st == S_DO1 |-> !o_ready && stk_we && stk_wd == r.loop_counter_reg
			##1 !o_ready && stk_we && stk_wd == r.pend_start
			##1 o_loop_active && r.sp == $past(r.sp, 2) + STK_ONE + STK_ONE;
	endproperty
	a_loop_push: assert property (p_loop_push) else $error("loop setup push wrong");

	property p_repeat_masks;
		r.st == S_REPEAT |=> !o_irq_take && !o_ready;
	endproperty
	a_repeat_masks: assert property (p_repeat_masks) else $error("irq or fetch during repeat");

	property p_stop;
		acc_short && in_opc == OP_STOP |=> (o_osc_off && o_low_power && !o_ready) [*2];
	endproperty
	a_stop: assert property (p_stop) else $error("stop not entered");

	property p_wait;
		r.st == S_WAIT && i_irq_req |=> o_irq_take && !o_low_power;
	endproperty
	a_wait: assert property (p_wait) else $error("wait did not wake");

	property p_illegal;
		acc_short && in_opc == OP_ILLEGAL |=> o_illegal_irq;
	endproperty
	a_illegal: assert property (p_illegal) else $error("illegal opcode missed");

	property p_periph_reset;
		acc_short && in_opc == OP_PERIPH_RESET |=> o_periph_rst && $stable(o_ccr) && $stable(o_loop_active);
	endproperty
	a_periph_reset: assert property (p_periph_reset) else $error("peripheral reset wrong");

	property p_two_word;
		r.st == S_IDLE && r.ready && i_instr_valid && i_instr_word[LONG_BIT] |=> r.st == S_EXT && o_ready;
	endproperty
	a_two_word: assert property (p_two_word) else $error("second word not awaited");
endmodule

// ### src/dicc_stack_mem.sv
// System stack storage with registered read data
`timescale 1ns/1ps
module dicc_stack_mem import dicc_pkg::*; (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_wr_en,
	input wire logic [STK_AW-1:0] i_wr_addr,
	input wire logic [STK_DW-1:0] i_wr_data,
	input wire logic [STK_AW-1:0] i_rd_addr,
	output logic [STK_DW-1:0] o_rd_data
);
	logic [STK_DW-1:0] mem_q [2**STK_AW];
	logic [STK_DW-1:0] rd_q;

	// Storage is left unreset; only the read register has a known value
	always_ff @(posedge i_ref_clk) begin
		if (i_wr_en) begin
			mem_q[i_wr_addr] <= i_wr_data;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rd_q <= '0;
		end else begin
			rd_q <= mem_q[i_rd_addr];
		end
	end

	assign o_rd_data = rd_q;
endmodule

// ### verification/tb_dsp_instruction_class_control.sv
// Self-checking testbench for the instruction class control block
`timescale 1ns/1ps
module tb_dsp_instruction_class_control import dicc_pkg::*;;
	logic i_ref_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_instr_valid = 1'b0;
	logic [23:0] i_instr_word = 24'h000000;
	logic [15:0] i_instr_pc = 16'h0000;
	logic [23:0] i_src_word = 24'h000000;
	logic [23:0] i_acc_a_mid = 24'h000000;
	logic [23:0] i_acc_b_mid = 24'h000000;
	logic [23:0] i_mem_word = 24'h000000;
	logic i_limit_hit = 1'b0;
	logic i_irq_req = 1'b0;
	logic o_ready, o_result_we, o_result_to_b, o_par_move_en, o_mem_we, o_jump, o_jump_sub;
	logic o_loop_redirect, o_loop_active, o_irq_take, o_illegal_irq, o_soft_irq, o_periph_rst;
	logic o_osc_off, o_low_power;
	logic [23:0] o_result, o_mem_wdata;
	logic [7:0] o_ccr, o_mode_reg;
	logic [15:0] o_target, o_redirect_addr;
	int fail_count = 0;
	int checks = 0;

	dicc_top dicc_top_inst (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_instr_valid(i_instr_valid),
		.i_instr_word(i_instr_word), .i_instr_pc(i_instr_pc), .i_src_word(i_src_word),
		.i_acc_a_mid(i_acc_a_mid), .i_acc_b_mid(i_acc_b_mid), .i_mem_word(i_mem_word),
		.i_limit_hit(i_limit_hit), .i_irq_req(i_irq_req), .o_ready(o_ready), .o_result(o_result),
		.o_result_we(o_result_we), .o_result_to_b(o_result_to_b), .o_ccr(o_ccr), .o_mode_reg(o_mode_reg),
		.o_par_move_en(o_par_move_en), .o_mem_we(o_mem_we), .o_mem_wdata(o_mem_wdata), .o_jump(o_jump),
		.o_jump_sub(o_jump_sub), .o_target(o_target), .o_loop_redirect(o_loop_redirect),
		.o_redirect_addr(o_redirect_addr), .o_loop_active(o_loop_active), .o_irq_take(o_irq_take),
		.o_illegal_irq(o_illegal_irq), .o_soft_irq(o_soft_irq), .o_periph_rst(o_periph_rst),
		.o_osc_off(o_osc_off), .o_low_power(o_low_power));

	initial begin
		forever #5 i_ref_clk = ~i_ref_clk;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [23:0] mk(input logic [4:0] op, input logic dst, input logic lng,
		input logic [11:0] low);
		return {op, dst, 5'h00, lng, low};
	endfunction

	task automatic final_report();
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk_bit(input string name, input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %0b seen %0b", name, exp, got);
		end
	endtask

	task automatic chk_word(input string name, input logic [23:0] exp, input logic [23:0] got);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Called 1 ns after an edge; returns 1 ns after the edge that took the word
	// One idle edge first, so valid never falls and rises in the same step
	task automatic issue(input logic [23:0] w);
		int n;
		n = 0;
		@(posedge i_ref_clk);
		#1;
		i_instr_valid = 1'b1;
		i_instr_word = w;
		while (o_ready !== 1'b1 && n < 50) begin
			@(posedge i_ref_clk);
			#1;
			n++;
		end
		if (n == 50) begin
			fail_count++;
			$display("ERROR ready wait expected 1 seen 0");
		end
		@(posedge i_ref_clk);
		#1;
		i_instr_valid = 1'b0;
		i_instr_pc = i_instr_pc + 16'h0001;
	endtask

	// Lets an edge pass before moving the fetch address
	task automatic at_pc(input logic [15:0] pc);
		@(posedge i_ref_clk);
		#1;
		i_instr_pc = pc;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_logic();
		logic [4:0] ops [5];
		logic dsts [5];
		logic [23:0] res [5];
		logic [7:0] cc [5];
		ops = '{OP_OR, OP_LOGIC_SHIFT_LEFT, OP_ROTATE_LEFT, OP_ROTATE_RIGHT, OP_LOGIC_SHIFT_RIGHT};
		dsts = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
		res = '{24'hff34ff, 24'hfe01fe, 24'hfe01ff, 24'h891a2b, 24'h091a2b};
		cc = '{8'h08, 8'h09, 8'h09, 8'h08, 8'h00};
		i_acc_a_mid = 24'hff00ff;
		i_src_word = 24'hf0f0f0;
		issue(mk(OP_AND, 1'b0, 1'b0, 12'h000));
		chk_word("and result", 24'hf000f0, o_result);
		chk_bit("and we", 1'b1, o_result_we);
		chk_bit("and to b", 1'b0, o_result_to_b);
		chk_word("and ccr", 24'h000008, {16'h0000, o_ccr});
		chk_bit("and par move", 1'b1, o_par_move_en);
		i_acc_b_mid = 24'h123456;
		i_src_word = 24'h123456;
		issue(mk(OP_EXCLUSIVE_OR, 1'b1, 1'b0, 12'h000));
		chk_word("xor result", 24'h000000, o_result);
		chk_bit("xor to b", 1'b1, o_result_to_b);
		chk_word("xor ccr", 24'h000004, {16'h0000, o_ccr});
		// Rotates take the carry left by the op before, so order matters
		for (int i = 0; i < 5; i++) begin
			issue(mk(ops[i], dsts[i], 1'b0, 12'h000));
			chk_word("logic result", res[i], o_result);
			chk_word("logic ccr", {16'h0000, cc[i]}, {16'h0000, o_ccr});
			chk_bit("logic to b", dsts[i], o_result_to_b);
		end
	endtask

	task automatic t_ctrl_imm();
		issue(mk(OP_OR_IMM_TO_CONTROL, 1'b0, 1'b0, 12'h041));
		chk_word("or imm ccr", 24'h000041, {16'h0000, o_ccr});
		chk_bit("or imm par move", 1'b0, o_par_move_en);
		chk_bit("or imm we", 1'b0, o_result_we);
		issue(mk(OP_AND_IMM_TO_CONTROL, 1'b0, 1'b0, 12'h001));
		chk_word("and imm ccr", 24'h000001, {16'h0000, o_ccr});
		chk_bit("and imm par move", 1'b0, o_par_move_en);
		issue(mk(OP_OR_IMM_TO_CONTROL, 1'b1, 1'b0, 12'h05a));
		issue(mk(OP_AND_IMM_TO_CONTROL, 1'b1, 1'b0, 12'h00f));
		chk_word("imm mr", 24'h00000a, {16'h0000, o_mode_reg});
		chk_word("imm mr ccr", 24'h000001, {16'h0000, o_ccr});
	endtask

	task automatic t_bits();
		logic [4:0] ops [3];
		logic [23:0] exp [3];
		ops = '{OP_BIT_CLEAR, OP_BIT_SET, OP_BIT_CHANGE};
		exp = '{24'h00000b, 24'h00000f, 24'h00000b};
		i_mem_word = 24'h00000f;
		for (int i = 0; i < 3; i++) begin
			issue(mk(ops[i], 1'b0, 1'b0, 12'h002));
			chk_word("bit wdata", exp[i], o_mem_wdata);
			chk_bit("bit we", 1'b1, o_mem_we);
			chk_bit("bit carry", 1'b1, o_ccr[CCR_C]);
			chk_bit("bit par move", 1'b0, o_par_move_en);
		end
		issue(mk(OP_BIT_TEST, 1'b0, 1'b0, 12'h003));
		chk_bit("bit test we", 1'b0, o_mem_we);
		chk_bit("bit test carry", 1'b1, o_ccr[CCR_C]);
		i_mem_word = 24'h000000;
		issue(mk(OP_BIT_SET, 1'b0, 1'b0, 12'h005));
		chk_word("set bit5", 24'h000020, o_mem_wdata);
		chk_bit("set bit5 carry", 1'b0, o_ccr[CCR_C]);
	endtask

	task automatic t_branch();
		logic [4:0] ops [4];
		logic tk [4];
		logic sub [4];
		ops = '{OP_JUMP_IF_CLEAR, OP_JUMP_IF_SET, OP_CALL_IF_CLEAR, OP_CALL_IF_SET};
		tk = '{1'b1, 1'b0, 1'b1, 1'b0};
		sub = '{1'b0, 1'b0, 1'b1, 1'b0};
		i_mem_word = 24'h000000;
		for (int i = 0; i < 4; i++) begin
			issue(mk(ops[i], 1'b0, 1'b1, 12'h000));
			issue(24'h001230 + 24'(i));
			chk_bit("branch taken", tk[i], o_jump | o_jump_sub);
			chk_bit("branch sub", sub[i], o_jump_sub);
			chk_bit("branch par move", 1'b0, o_par_move_en);
			if (tk[i] === 1'b1) begin
				chk_word("branch target", 24'h001230 + 24'(i), {8'h00, o_target});
			end
		end
		issue(mk(OP_JUMP, 1'b0, 1'b1, 12'h000));
		issue(24'h004567);
		chk_bit("jump", 1'b1, o_jump);
		chk_word("jump target", 24'h004567, {8'h00, o_target});
		chk_bit("jump par move", 1'b0, o_par_move_en);
	endtask

	task automatic t_move();
		issue(mk(OP_OR_IMM_TO_CONTROL, 1'b0, 1'b0, 12'h005));
		i_limit_hit = 1'b1;
		issue(mk(OP_MOVE, 1'b0, 1'b0, 12'h000));
		i_limit_hit = 1'b0;
		chk_word("move ccr", 24'h000045, {16'h0000, o_ccr});
		chk_bit("move par move", 1'b1, o_par_move_en);
		issue(mk(OP_MOVE, 1'b0, 1'b0, 12'h000));
		chk_word("plain move ccr", 24'h000045, {16'h0000, o_ccr});
	endtask

	task automatic t_events();
		issue(mk(OP_ILLEGAL, 1'b0, 1'b0, 12'h000));
		chk_bit("illegal irq", 1'b1, o_illegal_irq);
		issue(mk(OP_PERIPH_RESET, 1'b0, 1'b0, 12'h000));
		chk_bit("periph reset", 1'b1, o_periph_rst);
		chk_bit("periph par move", 1'b0, o_par_move_en);
		issue(mk(OP_SOFT_INTERRUPT, 1'b0, 1'b0, 12'h000));
		chk_bit("soft irq", 1'b1, o_soft_irq);
	endtask

	task automatic t_loop();
		// One-word body; the count comes from memory, the field says zero
		at_pc(16'h0100);
		i_mem_word = 24'h000002;
		issue(mk(OP_HW_LOOP_START, 1'b0, 1'b1, 12'h800));
		issue(24'h000102);
		for (int i = 0; i < 2; i++) begin
			at_pc(16'h0102);
			issue(mk(OP_AND, 1'b0, 1'b0, 12'h000));
			chk_bit("loop redirect", i == 0, o_loop_redirect);
			chk_bit("loop alu", 1'b1, o_result_we);
			chk_bit("loop active", 1'b1, o_loop_active);
		end
		chk_word("loop start", 24'h000102, {8'h00, o_redirect_addr});
		issue(mk(OP_NOP, 1'b0, 1'b0, 12'h000));
		chk_bit("loop ended", 1'b0, o_loop_active);
		// Inner loop aborted; the outer one must resume from the stack
		at_pc(16'h0200);
		issue(mk(OP_HW_LOOP_START, 1'b0, 1'b1, 12'h003));
		issue(24'h000210);
		issue(mk(OP_HW_LOOP_START, 1'b0, 1'b1, 12'h005));
		issue(24'h000208);
		issue(mk(OP_HW_LOOP_ABORT, 1'b0, 1'b0, 12'h000));
		chk_bit("abort par move", 1'b0, o_par_move_en);
		at_pc(16'h0210);
		issue(mk(OP_NOP, 1'b0, 1'b0, 12'h000));
		chk_bit("outer redirect", 1'b1, o_loop_redirect);
		chk_word("outer start", 24'h000202, {8'h00, o_redirect_addr});
		issue(mk(OP_HW_LOOP_ABORT, 1'b0, 1'b0, 12'h000));
		issue(mk(OP_NOP, 1'b0, 1'b0, 12'h000));
		chk_bit("outer ended", 1'b0, o_loop_active);
	endtask

	task automatic t_repeat();
		int we_n;
		int last_we;
		int first_take;
		we_n = 0;
		last_we = -1;
		first_take = -1;
		i_acc_a_mid = 24'h00ff00;
		issue(mk(OP_REPEAT_NEXT, 1'b0, 1'b0, 12'h003));
		issue(mk(OP_NOT, 1'b0, 1'b0, 12'h000));
		// Request raised mid-repeat; it must wait for the last pass
		i_irq_req = 1'b1;
		for (int n = 0; n < 30; n++) begin
			if (o_result_we === 1'b1) begin
				we_n++;
				last_we = n;
			end
			if (o_irq_take === 1'b1 && first_take < 0) begin
				first_take = n;
				i_irq_req = 1'b0;
			end
			@(posedge i_ref_clk);
			#1;
		end
		chk_word("repeat passes", 24'h000003, we_n[23:0]);
		chk_bit("irq after repeat", 1'b1, first_take > last_we);
		chk_word("not result", 24'hff00ff, o_result);
	endtask

	task automatic t_low(input logic [4:0] op, input logic osc);
		int n;
		n = 0;
		issue(mk(op, 1'b0, 1'b0, 12'h000));
		@(posedge i_ref_clk);
		#1;
		chk_bit("low power", 1'b1, o_low_power);
		chk_bit("osc off", osc, o_osc_off);
		chk_bit("halted ready", 1'b0, o_ready);
		i_irq_req = 1'b1;
		while (o_irq_take !== 1'b1 && n < 20) begin
			@(posedge i_ref_clk);
			#1;
			n++;
		end
		i_irq_req = 1'b0;
		chk_bit("wake take", 1'b1, o_irq_take);
		@(posedge i_ref_clk);
		#1;
		chk_bit("awake", 1'b0, o_low_power);
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge i_ref_clk);
		#1;
		i_sys_rst = 1'b0;
		repeat (2) @(posedge i_ref_clk);
		#1;
		t_logic();
		t_ctrl_imm();
		t_bits();
		t_branch();
		t_move();
		t_events();
		t_loop();
		t_repeat();
		t_low(OP_STOP, 1'b1);
		t_low(OP_WAIT, 1'b0);
		final_report();
	end

	// Whole run needs well under 1000 cycles
	initial begin
		#200000;
		fail_count++;
		final_report();
	end
endmodule
